// ---- rtl/nmil_core.sv ----
// Nonmaskable interrupt entry logic beside the maskable request resolver
`timescale 1ns/10ps
`include "nmil_map.svh"
module nmil_core (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // External nonmaskable request pin
    input wire logic nmi_req,
    // Maskable requests, already synchronised, with per-source masks
    input wire logic [`NMIL_SRC_W-1:0] mask_req,
    input wire logic [`NMIL_SRC_W-1:0] mask_dis,
    // Instruction boundary from the core
    input wire logic instr_boundary,
    // Flag instructions from the core
    input wire logic set_enable_flag_instruction,
    input wire logic clear_enable_flag_instruction,
    // End of interrupt, one bit per maskable source
    input wire logic [`NMIL_SRC_W-1:0] eoi,
    // Entry record to the core
    output nmil_pkg::nmil_entry_t entry,
    // Flag and pending state
    output logic enable_flag,
    output logic nmi_pending,
    // Maskable in-service and request registers
    output logic [`NMIL_SRC_W-1:0] in_service,
    output logic [`NMIL_SRC_W-1:0] req_reg
);
    import nmil_pkg::*;

    // Pin edge, pending latch and interrupt flag
    logic nmi_rise;
    logic pend_reg;
    logic if_reg;

    // Maskable request state
    logic [`NMIL_SRC_W-1:0] isr_reg;
    logic [`NMIL_SRC_W-1:0] irr_reg;
    logic [`NMIL_SRC_W-1:0] irr_next;
    logic [`NMIL_SRC_W-1:0] isr_next;

    // Arbitration
    nmil_pick_t pick;
    logic [`NMIL_SRC_W-1:0] eligible;
    logic [`NMIL_SRC_W-1:0] grant;
    logic mask_open;
    logic take_nmi;
    logic take_mask;

    // Entry state and record
    nmil_state_t state_reg;
    logic [`NMIL_IDX_W-1:0] src_idx_reg;
    logic [7:0] vec_type_reg;
    logic [9:0] vec_addr_reg;

    // Lowest index wins; masked or in-service-blocked sources drop out
    function automatic nmil_pick_t pick_first(input logic [`NMIL_SRC_W-1:0] v);
        nmil_pick_t p;
        p = '0;
        for (int i = `NMIL_SRC_W - 1; i >= 0; i--) begin
            if (v[i]) begin
                p.found = 1'b1;
                p.idx = i[`NMIL_IDX_W-1:0];
            end
        end
        return p;
    endfunction

    // Lowest index of in-service bits bounds what may nest
    function automatic logic [`NMIL_SRC_W-1:0] below(input logic [`NMIL_SRC_W-1:0] v);
        logic [`NMIL_SRC_W-1:0] m;
        m = '0;
        for (int i = `NMIL_SRC_W - 1; i >= 0; i--) begin
            if (v[i]) begin
                m = '0;
            end else begin
                m[i] = 1'b1;
            end
        end
        for (int i = 0; i < `NMIL_SRC_W; i++) begin
            if (v[i]) begin
                m = m & ((`NMIL_SRC_W'(1) << i) - `NMIL_SRC_W'(1));
            end
        end
        return m;
    endfunction

    // Grant bit for one source index
    function automatic logic [`NMIL_SRC_W-1:0] onehot(input logic [`NMIL_IDX_W-1:0] idx);
        return `NMIL_SRC_W'(1) << idx;
    endfunction

    // Maskable vector type: fixed base plus source index
    function automatic logic [7:0] mask_vec_type(input logic [`NMIL_IDX_W-1:0] idx);
        return `NMIL_MASK_VEC_BASE + {5'h00, idx};
    endfunction

    // Kind of entry issued at this edge; every state leaves the same way
    function automatic nmil_state_t entry_kind(input logic tn, input logic tm);
        if (tn) begin
            return NMIL_ENTER_NMI;
        end else if (tm) begin
            return NMIL_ENTER_MASK;
        end else begin
            return NMIL_IDLE;
        end
    endfunction

    nmil_sync u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .din(nmi_req),
        .rise(nmi_rise)
    );

    // No mask input reaches the nonmaskable path; it wins every boundary
    assign take_nmi = instr_boundary & pend_reg;
    // Arbitration sees only maskable bits; the nonmaskable path keeps no in-service state to consult
    assign eligible = irr_reg & ~mask_dis & below(isr_reg);
    assign pick = pick_first(eligible);
    // A waiting nonmaskable request holds off every maskable source
    assign mask_open = if_reg & ~pend_reg;
    assign take_mask = instr_boundary & mask_open & pick.found;
    // One-hot grant of the winning source
    assign grant = take_mask ? onehot(pick.idx) : '0;

    // Pending latch: a new edge during the taking cycle wins so none is lost
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_reg <= `NMIL_PEND_RESET;
        end else if (nmi_rise) begin
            pend_reg <= 1'b1;
        end else if (take_nmi) begin
            pend_reg <= 1'b0;
        end
    end

    // Interrupt enable flag cleared on every hardware entry
    // Entry beats a same-cycle set instruction so no handler starts with maskable sources open
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            if_reg <= `NMIL_FLAG_RESET;
        end else if (take_nmi || take_mask) begin
            if_reg <= 1'b0;
        end else if (set_enable_flag_instruction) begin
            if_reg <= 1'b1;
        end else if (clear_enable_flag_instruction) begin
            if_reg <= 1'b0;
        end
    end

    // Per-source next state; a grant wins over an end of interrupt in the same cycle
    generate
        for (genvar g = 0; g < `NMIL_SRC_W; g++) begin : g_src
            assign irr_next[g] = (irr_reg[g] | mask_req[g]) & ~grant[g];
            assign isr_next[g] = (isr_reg[g] & ~eoi[g]) | grant[g];
        end
    endgenerate

    // Maskable request and in-service registers; the nonmaskable source has no bit here
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irr_reg <= `NMIL_MASK_RESET;
            isr_reg <= `NMIL_MASK_RESET;
        end else begin
            irr_reg <= irr_next;
            isr_reg <= isr_next;
        end
    end

    // Entry state: marks which kind of entry was issued at the previous edge, idle if none
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= NMIL_IDLE;
        end else begin
            // Any state leaves by the same decode, so a nonmaskable entry may follow any entry
            case (state_reg)
                NMIL_IDLE: begin
                    state_reg <= entry_kind(take_nmi, take_mask);
                end
                NMIL_ENTER_NMI: begin
                    state_reg <= entry_kind(take_nmi, take_mask);
                end
                NMIL_ENTER_MASK: begin
                    state_reg <= entry_kind(take_nmi, take_mask);
                end
                default: begin
                    state_reg <= NMIL_IDLE;
                end
            endcase
        end
    end

    // Entry record loads on a take and then stands until the next one; nonmaskable vector is fixed
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            src_idx_reg <= `NMIL_IDX_RESET;
            vec_type_reg <= `NMIL_TYPE_RESET;
            vec_addr_reg <= `NMIL_ADDR_RESET;
        end else if (take_nmi) begin
            src_idx_reg <= '0;
            vec_type_reg <= `NMIL_VEC_TYPE;
            vec_addr_reg <= `NMIL_VEC_ADDR;
        end else if (take_mask) begin
            src_idx_reg <= pick.idx;
            vec_type_reg <= mask_vec_type(pick.idx);
            vec_addr_reg <= {mask_vec_type(pick.idx), 2'b00};
        end
    end

    // Take and kind come straight from the entry state, so they pulse once per entry
    always_comb begin
        entry.take = (state_reg != NMIL_IDLE);
        entry.is_nmi = (state_reg == NMIL_ENTER_NMI);
        entry.src_idx = src_idx_reg;
        entry.vec_type = vec_type_reg;
        entry.vec_addr = vec_addr_reg;
    end
    assign enable_flag = if_reg;
    assign nmi_pending = pend_reg;
    assign in_service = isr_reg;
    assign req_reg = irr_reg;
endmodule

// ---- rtl/nmil_map.svh ----
// Constants and operation summary for the nonmaskable interrupt logic
// Summary of operation
// - Nonmaskable request is highest priority hardware interrupt; software cannot mask it.
// - Asserted request always redirects execution to the nonmaskable vector table entry.
// - Nonmaskable request stays out of maskable priority arbitration.
// - No in-service or request register bit exists for the nonmaskable source.
// - A fresh request is accepted while a nonmaskable handler runs, nesting.
// - Taking any hardware interrupt clears the processor interrupt enable flag.
// - Re-enabled maskable interrupts inside the handler resolve as if no service ran.
// - Rising request edge is synchronized and entry begins at next instruction boundary.
`ifndef NMIL_MAP_SVH
`define NMIL_MAP_SVH
`define NMIL_VEC_TYPE 8'h02
`define NMIL_VEC_ADDR 10'h008
`define NMIL_MASK_RESET 8'h00
`define NMIL_SRC_W 8
`define NMIL_IDX_W 3
`define NMIL_MASK_VEC_BASE 8'h08
`define NMIL_PEND_RESET 1'h0
`define NMIL_FLAG_RESET 1'h0
`define NMIL_IDX_RESET 3'h0
`define NMIL_TYPE_RESET 8'h00
`define NMIL_ADDR_RESET 10'h000
`endif

// ---- rtl/nmil_pkg.sv ----
// Types for the nonmaskable interrupt logic
`include "nmil_map.svh"
package nmil_pkg;
    typedef enum logic [1:0] {
        NMIL_IDLE,
        NMIL_ENTER_NMI,
        NMIL_ENTER_MASK
    } nmil_state_t;

    typedef struct packed {
        logic take;
        logic is_nmi;
        logic [`NMIL_IDX_W-1:0] src_idx;
        logic [7:0] vec_type;
        logic [9:0] vec_addr;
    } nmil_entry_t;

    typedef struct packed {
        logic found;
        logic [`NMIL_IDX_W-1:0] idx;
    } nmil_pick_t;
endpackage

// ---- rtl/nmil_sync.sv ----
// Two-stage synchroniser with rising-edge detect
`timescale 1ns/10ps
module nmil_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Async input and detected edge
    input wire logic din,
    output logic rise
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= din;
            sync_reg <= meta_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            last_reg <= 1'b0;
        end else begin
            last_reg <= sync_reg;
        end
    end

    assign rise = sync_reg & ~last_reg;
endmodule

// ---- tb/nmil_core_asserts.sv ----
// Port assertions for the nonmaskable interrupt logic
`timescale 1ns/10ps
`include "nmil_map.svh"
module nmil_core_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Watched ports
    input wire logic nmi_req,
    input wire logic instr_boundary,
    input wire nmil_pkg::nmil_entry_t entry,
    input wire logic enable_flag,
    input wire logic nmi_pending
);
    import nmil_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_req;
        nmi_pending && instr_boundary;
    endsequence
    // Pin steady high for four samples, so no second edge is in flight
    sequence s_steady;
        nmi_req && $past(nmi_req) && $past(nmi_req, 2) && $past(nmi_req, 3);
    endsequence
    property p_take; s_req |=> entry.take && entry.is_nmi; endproperty
    property p_vec; entry.take && entry.is_nmi |-> entry.vec_type == `NMIL_VEC_TYPE && entry.vec_addr == `NMIL_VEC_ADDR;
    endproperty
    property p_ie; entry.take |-> !enable_flag; endproperty
    property p_once; s_req ##0 s_steady |=> !nmi_pending; endproperty
    property p_arb; entry.take && !entry.is_nmi |-> !$past(nmi_pending); endproperty
    property p_nomask; s_req ##0 !enable_flag |=> entry.take; endproperty
    property p_bound; $rose(entry.take) |-> $past(instr_boundary); endproperty
    property p_hold; nmi_pending && !instr_boundary |=> nmi_pending; endproperty
    a_take: assert property (p_take) else $error("nmi not taken");
    a_vec: assert property (p_vec) else $error("bad nmi vector");
    a_ie: assert property (p_ie) else $error("flag not cleared");
    a_once: assert property (p_once) else $error("pending kept");
    a_arb: assert property (p_arb) else $error("maskable beat nmi");
    a_nomask: assert property (p_nomask) else $error("nmi masked");
    a_bound: assert property (p_bound) else $error("take off boundary");
    a_hold: assert property (p_hold) else $error("pending lost");
endmodule

bind nmil_core nmil_core_asserts i_chk (.clk, .rst_b, .nmi_req, .instr_boundary, .entry, .enable_flag, .nmi_pending);

// ---- tb/nmil_src_model.sv ----
// External nonmaskable request source
`timescale 1ns/10ps
module nmil_src_model (
    // Clock
    input wire logic clk,
    // Command and request pin
    input wire logic fire,
    output logic nmi_req
);
    logic [2:0] cnt = 3'h0;
    // Held six clocks, well above the one-clock minimum
    always @(posedge clk) begin
        cnt <= fire ? 3'h6 : (cnt != 3'h0 ? cnt - 3'h1 : cnt);
    end
    assign nmi_req = (cnt != 3'h0);
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the nonmaskable interrupt logic
`timescale 1ns/10ps
`include "nmil_map.svh"
module tb_top;
    import nmil_pkg::*;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic fire = 1'h0;
    logic nmi_req;
    logic [7:0] mask_req = 8'h00;
    logic [7:0] mask_dis = 8'h00;
    logic bnd = 1'h0;
    logic set_en = 1'h0;
    logic clr_en = 1'h0;
    logic [7:0] eoi = 8'h00;
    nmil_entry_t entry;
    logic enable_flag, nmi_pending;
    logic [7:0] in_service, req_reg;
    int n_fail = 0;
    int compares = 0;
    initial forever #20 clk = ~clk;
    nmil_src_model i_src (.clk(clk), .fire(fire), .nmi_req(nmi_req));
    nmil_core i_dut (.clk(clk), .rst_b(rst_b), .nmi_req(nmi_req), .mask_req(mask_req), .mask_dis(mask_dis),
        .instr_boundary(bnd), .set_enable_flag_instruction(set_en), .clear_enable_flag_instruction(clr_en),
        .eoi(eoi), .entry(entry), .enable_flag(enable_flag), .nmi_pending(nmi_pending),
        .in_service(in_service), .req_reg(req_reg));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task finish_test;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task pulse_set;
        set_en = 1'h1;
        @(negedge clk);
        set_en = 1'h0;
    endtask
    // Fire the source and wait, bounded, until the request is pending
    task raise_nmi;
        fire = 1'h1;
        @(negedge clk);
        fire = 1'h0;
        mask_req = 8'h00;
        repeat (20) if (nmi_pending !== 1'h1) @(negedge clk);
    endtask
    task wait_take;
        repeat (20) if (entry.take !== 1'h1) @(negedge clk);
        chk(entry.take, 1'h1);
    endtask
    // Entry with every source masked; a second call nests inside the first handler
    task t_nmi(input logic pre_en);
        mask_dis = 8'hFF;
        if (pre_en) pulse_set;
        raise_nmi;
        bnd = 1'h1;
        wait_take;
        chk({entry.is_nmi, entry.vec_type, entry.vec_addr}, {1'h1, `NMIL_VEC_TYPE, `NMIL_VEC_ADDR});
        chk({enable_flag, nmi_pending}, 2'h0);
        @(negedge clk);
        chk(entry.take, 1'h0);
        bnd = 1'h0;
        mask_dis = 8'h00;
        repeat (6) @(negedge clk);
    endtask
    // A waiting maskable source loses to the nmi, then runs once software sets the flag again
    task t_arb;
        pulse_set;
        mask_req = 8'h08;
        raise_nmi;
        chk(req_reg, 8'h08);
        bnd = 1'h1;
        wait_take;
        chk(entry.is_nmi, 1'h1);
        repeat (2) @(negedge clk);
        chk(entry.take, 1'h0);
        pulse_set;
        wait_take;
        chk({entry.is_nmi, entry.src_idx, entry.vec_type, entry.vec_addr}, {1'h0, 3'h3, 8'h0B, 10'h02C});
        @(negedge clk);
        chk(in_service, 8'h08);
        bnd = 1'h0;
    endtask
    // An in-service source holds off a lower one until its end of interrupt; flag instructions steer the flag
    task t_eoi;
        mask_req = 8'h20;
        pulse_set;
        mask_req = 8'h00;
        bnd = 1'h1;
        @(negedge clk);
        chk({entry.take, enable_flag, req_reg}, {1'h0, 1'h1, 8'h20});
        eoi = 8'h08;
        @(negedge clk);
        eoi = 8'h00;
        wait_take;
        chk({entry.is_nmi, entry.src_idx, entry.vec_type, entry.vec_addr}, {1'h0, 3'h5, 8'h0D, 10'h034});
        chk({in_service, enable_flag}, {8'h20, 1'h0});
        bnd = 1'h0;
        pulse_set;
        chk(enable_flag, 1'h1);
        clr_en = 1'h1;
        @(negedge clk);
        clr_en = 1'h0;
        chk(enable_flag, 1'h0);
    endtask
    initial begin
        repeat (10) @(negedge clk);
        rst_b = 1'h1;
        @(negedge clk);
        chk({entry, enable_flag, nmi_pending}, 32'h0000_0000);
        t_nmi(1'h1);
        t_nmi(1'h0);
        t_arb;
        t_eoi;
        finish_test;
    end
    initial begin
        #100000;
        n_fail++;
        finish_test;
    end
endmodule
